/* ccp_unit_pkg.sv */
// Constants, register map and state layout of the capture/compare/PWM unit.
// Assumes a 50 MHz clock that stands for the oscillator (one Tosc per edge).
package ccp_unit_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 10;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_UNIT_ONE_CONTROL = 8'h17;
  localparam logic [7:0] IDX_UNIT_TWO_CONTROL = 8'h1d;
  localparam logic [7:0] IDX_DUTY_MSB = 8'h30;
  localparam logic [7:0] IDX_DUTY_SHADOW = 8'h31;
  localparam logic [7:0] IDX_PERIOD = 8'h32;
  localparam logic [7:0] IDX_PERIOD_TIMER = 8'h33;
  localparam logic [7:0] IDX_TIMER_CONFIG = 8'h34;
  localparam logic [7:0] IDX_FLAGS = 8'h35;
  localparam logic [7:0] IDX_COMPANION_LO = 8'h36;
  localparam logic [7:0] IDX_COMPANION_HI = 8'h37;
  // Mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
  localparam logic [1:0] PWM_TOP = 2'h3;
  localparam logic [1:0] CMP_TOP = 2'h2;
  localparam logic [1:0] CAP_TOP = 2'h1;
  // Edge counts for the capture prescale
  localparam logic [3:0] CAP_LAST_1 = 4'h0;
  localparam logic [3:0] CAP_LAST_4 = 4'h3;
  localparam logic [3:0] CAP_LAST_16 = 4'hf;
  // Timer prescale limits (1, 4, 16) in instruction cycles
  localparam logic [3:0] PRE_LAST_1 = 4'h0;
  localparam logic [3:0] PRE_LAST_4 = 4'h3;
  localparam logic [3:0] PRE_LAST_16 = 4'hf;
  localparam logic [1:0] PRE_SEL_1 = 2'h0;
  localparam logic [1:0] PRE_SEL_4 = 2'h1;
  // Oscillator periods per instruction cycle, last quarter index
  localparam int TOSC_PER_CYCLE = 4;
  localparam logic [1:0] Q_LAST = 2'(TOSC_PER_CYCLE - 1);
  localparam logic [7:0] RESET_PERIOD = 8'hff;
  localparam int FLAG_MATCH_BIT = 0;
  localparam int FLAG_TIMER_BIT = 1;

  typedef struct packed {
    logic [1:0] quarter;
    logic [3:0] presc;
    logic [7:0] timer;
    logic [7:0] period;
    logic [1:0] pre_sel;
    logic [3:0] post_sel;
    logic [3:0] post_cnt;
    logic [5:0] control;
    logic [7:0] duty_msb;
    logic [7:0] shadow;
    logic [1:0] lsb_latch;
    logic flag_match;
    logic flag_timer;
    logic pin;
    logic [15:0] companion;
    logic cap_prev;
    logic [3:0] cap_cnt;
    logic conv_start;
    logic waitreq;
    logic [31:0] rdata;
  } state_t;
endpackage

/* ccp_unit.sv */
// Capture/compare/PWM unit with its period timer and companion timer.
// Assumes an Avalon-MM master and a capture pin synchronous to clock_in.
`timescale 1ns/1ps
module ccp_unit import ccp_unit_pkg::*; #(
  parameter bit SECOND_UNIT = 1'b0
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [DATA_W-1:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  output logic [DATA_W-1:0] readdata_out,
  output logic waitrequest_out,
  input wire logic capture_pin_in,
  output logic unit_output_pin_out,
  output logic conversion_start_out
);
  localparam logic [7:0] CTRL_IDX =
    SECOND_UNIT ? IDX_UNIT_TWO_CONTROL : IDX_UNIT_ONE_CONTROL;

  state_t s_reg;
  state_t s_next;
  logic [7:0] idx;
  logic wr_ok;
  logic rd_ok;
  logic [3:0] mode;
  logic is_pwm;
  logic is_cmp;
  logic is_cap;
  logic cycle_end;
  logic [3:0] pre_last;
  logic inc_tick;
  logic pmatch;
  logic [1:0] quarter_step;
  logic [3:0] presc_step;
  logic [7:0] timer_step;
  logic [1:0] ext_bits;
  logic [9:0] duty_word;
  logic duty_hit;
  logic cmp_evt;
  logic rise;
  logic fall;
  logic cap_edge;
  logic [3:0] cap_last;
  logic cap_evt;

  default clocking tick_cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  assign idx = address_in[ADDR_W-1:2];
  assign wr_ok = write_in && !s_reg.waitreq && byteenable_in[0];
  assign rd_ok = read_in && s_reg.waitreq;
  assign mode = s_reg.control[3:0];
  assign is_pwm = mode[3:2] == PWM_TOP;
  assign is_cmp = mode[3:2] == CMP_TOP;
  assign is_cap = mode[3:2] == CAP_TOP;
  assign cycle_end = s_reg.quarter == Q_LAST;
  assign pre_last = (s_reg.pre_sel == PRE_SEL_1) ? PRE_LAST_1 :
                    (s_reg.pre_sel == PRE_SEL_4) ? PRE_LAST_4 : PRE_LAST_16;
  // Period timer step: 4 Tosc times prescale
  assign inc_tick = cycle_end && (s_reg.presc == pre_last);
  assign pmatch = inc_tick && (s_reg.timer == s_reg.period);
  // Count value that the next edge brings
  assign quarter_step = s_reg.quarter + 2'h1;
  assign presc_step = !cycle_end ? s_reg.presc :
                      (s_reg.presc == pre_last) ? 4'h0 : s_reg.presc + 4'h1;
  assign timer_step = inc_tick ? s_reg.timer + 8'h1 : s_reg.timer;
  // Two low bits below the timer from quarter clock or prescaler
  assign ext_bits = (s_reg.pre_sel == PRE_SEL_1) ? quarter_step :
                    (s_reg.pre_sel == PRE_SEL_4) ? presc_step[1:0] :
                    presc_step[3:2];
  // Pin falls at the edge where the count reaches the duty
  assign duty_word = {s_reg.duty_msb, s_reg.control[5:4]};
  assign duty_hit = {s_reg.shadow, s_reg.lsb_latch} ==
                    {timer_step, ext_bits};
  assign cmp_evt = is_cmp && (s_reg.quarter == 2'h0) &&
                   (s_reg.companion == {s_reg.shadow, s_reg.duty_msb});
  assign rise = capture_pin_in && !s_reg.cap_prev;
  assign fall = !capture_pin_in && s_reg.cap_prev;
  assign cap_edge = (mode == MODE_CAP_FALL) ? fall : rise;
  assign cap_last = (mode == MODE_CAP_RISE4) ? CAP_LAST_4 :
                    (mode == MODE_CAP_RISE16) ? CAP_LAST_16 : CAP_LAST_1;
  assign cap_evt = is_cap && cap_edge && (s_reg.cap_cnt == cap_last);

  always_comb
  begin
    s_next = s_reg;
    s_next.conv_start = 1'b0;
    s_next.cap_prev = capture_pin_in;
    // Instruction-cycle quarters and timer prescaler
    s_next.quarter = s_reg.quarter + 2'h1;
    if (cycle_end)
    begin
      s_next.presc = (s_reg.presc == pre_last) ? 4'h0 : s_reg.presc + 4'h1;
      s_next.companion = s_reg.companion + 16'h1;
    end
    if (inc_tick)
    begin
      s_next.timer = s_reg.timer + 8'h1;
    end
    if (pmatch)
    begin
      s_next.timer = 8'h0;
      // Postscaler only paces the timer flag
      if (s_reg.post_cnt == s_reg.post_sel)
      begin
        s_next.post_cnt = 4'h0;
        s_next.flag_timer = 1'b1;
      end
      else
      begin
        s_next.post_cnt = s_reg.post_cnt + 4'h1;
      end
    end
    // PWM output; a duty past the period never matches
    if (is_pwm)
    begin
      if (pmatch)
      begin
        s_next.shadow = s_reg.duty_msb;
        s_next.lsb_latch = s_reg.control[5:4];
        s_next.pin = {s_reg.duty_msb, s_reg.control[5:4]} != 10'h0;
      end
      else if (duty_hit)
      begin
        s_next.pin = 1'b0;
      end
    end
    // Compare modes
    if (cmp_evt)
    begin
      s_next.flag_match = 1'b1;
      if (mode == MODE_CMP_SET)
      begin
        s_next.pin = 1'b1;
      end
      else if (mode == MODE_CMP_CLR)
      begin
        s_next.pin = 1'b0;
      end
      else if (mode == MODE_CMP_TRIG)
      begin
        s_next.companion = 16'h0;
        s_next.conv_start = SECOND_UNIT;
      end
    end
    // Capture modes with edge prescale
    if (is_cap && cap_edge)
    begin
      s_next.cap_cnt = (s_reg.cap_cnt == cap_last) ? 4'h0 :
                       s_reg.cap_cnt + 4'h1;
    end
    if (cap_evt)
    begin
      s_next.duty_msb = s_reg.companion[7:0];
      s_next.shadow = s_reg.companion[15:8];
      s_next.flag_match = 1'b1;
    end
    // Bus: one wait cycle, write at the edge waitrequest is low
    s_next.waitreq = !((read_in || write_in) && s_reg.waitreq);
    if (rd_ok)
    begin
      s_next.rdata = 32'h0;
      case (idx)
        CTRL_IDX: s_next.rdata = {26'h0, s_reg.control};
        IDX_DUTY_MSB: s_next.rdata = {24'h0, s_reg.duty_msb};
        IDX_DUTY_SHADOW: s_next.rdata = {24'h0, s_reg.shadow};
        IDX_PERIOD: s_next.rdata = {24'h0, s_reg.period};
        IDX_PERIOD_TIMER: s_next.rdata = {24'h0, s_reg.timer};
        IDX_TIMER_CONFIG: s_next.rdata = {26'h0, s_reg.post_sel,
                                          s_reg.pre_sel};
        IDX_FLAGS: s_next.rdata = {30'h0, s_reg.flag_timer,
                                   s_reg.flag_match};
        IDX_COMPANION_LO: s_next.rdata = {24'h0, s_reg.companion[7:0]};
        IDX_COMPANION_HI: s_next.rdata = {24'h0, s_reg.companion[15:8]};
        default: s_next.rdata = 32'h0;
      endcase
    end
    if (wr_ok)
    begin
      case (idx)
        CTRL_IDX:
        begin
          s_next.control = writedata_in[5:0];
          if (writedata_in[3:0] != mode)
          begin
            s_next.cap_cnt = 4'h0;
          end
          if (writedata_in[3:0] == MODE_OFF)
          begin
            s_next.pin = 1'b0;
            s_next.cap_cnt = 4'h0;
          end
        end
        IDX_DUTY_MSB: s_next.duty_msb = writedata_in[7:0];
        IDX_DUTY_SHADOW:
        begin
          if (!is_pwm)
          begin
            s_next.shadow = writedata_in[7:0];
          end
        end
        IDX_PERIOD: s_next.period = writedata_in[7:0];
        IDX_PERIOD_TIMER:
        begin
          s_next.timer = writedata_in[7:0];
          s_next.presc = 4'h0;
        end
        IDX_TIMER_CONFIG:
        begin
          s_next.pre_sel = writedata_in[1:0];
          s_next.post_sel = writedata_in[5:2];
        end
        IDX_FLAGS:
        begin
          // Write one clears; a same-cycle event still sets
          s_next.flag_match = (s_reg.flag_match &&
            !writedata_in[FLAG_MATCH_BIT]) || cmp_evt || cap_evt;
          s_next.flag_timer = (s_reg.flag_timer &&
            !writedata_in[FLAG_TIMER_BIT]) ||
            (pmatch && s_reg.post_cnt == s_reg.post_sel);
        end
        default:
        begin
          s_next.rdata = s_reg.rdata;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_reg <= '{quarter: 2'h0, presc: 4'h0, timer: 8'h0,
                 period: RESET_PERIOD, pre_sel: 2'h0, post_sel: 4'h0,
                 post_cnt: 4'h0, control: 6'h0, duty_msb: 8'h0,
                 shadow: 8'h0, lsb_latch: 2'h0, flag_match: 1'b0,
                 flag_timer: 1'b0, pin: 1'b0, companion: 16'h0,
                 cap_prev: 1'b0, cap_cnt: 4'h0, conv_start: 1'b0,
                 waitreq: 1'b1, rdata: 32'h0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign readdata_out = s_reg.rdata;
  assign waitrequest_out = s_reg.waitreq;
  assign unit_output_pin_out = s_reg.pin;
  assign conversion_start_out = s_reg.conv_start;

  // Checks
  a_pwm_sets_high: assert property (
    is_pwm && pmatch && !wr_ok && duty_word != 10'h0 |=> unit_output_pin_out)
    else $error("pwm pin not set at period end");
  a_pwm_zero_duty: assert property (
    is_pwm && pmatch && !wr_ok && duty_word == 10'h0 |=> !unit_output_pin_out)
    else $error("pwm pin set with zero duty");
  a_shadow_load: assert property (
    is_pwm && pmatch && !wr_ok |=>
    s_reg.shadow == $past(s_reg.duty_msb) && s_reg.timer == 8'h0)
    else $error("shadow or timer wrong after period match");
  a_pwm_clear_pin: assert property (
    is_pwm && !pmatch && duty_hit && !wr_ok |=> !unit_output_pin_out)
    else $error("pwm pin not cleared at duty match");
  a_shadow_read_only: assert property (
    is_pwm && wr_ok && idx == IDX_DUTY_SHADOW && !pmatch |=>
    $stable(s_reg.shadow))
    else $error("shadow written in pwm mode");
  a_ctrl_clear_low: assert property (
    wr_ok && idx == CTRL_IDX && writedata_in[3:0] == MODE_OFF |=>
    !unit_output_pin_out ##1 !unit_output_pin_out)
    else $error("pin not low after disable");
  a_ctrl_top_zero: assert property (
    rd_ok && idx == CTRL_IDX |=> readdata_out[7:6] == 2'h0)
    else $error("control top bits not zero");
  a_cmp_flag_set: assert property (
    cmp_evt |=> s_reg.flag_match)
    else $error("match flag not set");
  a_cmp_soft_keep: assert property (
    cmp_evt && mode == MODE_CMP_SOFT && !wr_ok |=>
    $stable(unit_output_pin_out))
    else $error("pin changed in soft compare");
  a_bus_answer: assert property (
    (read_in || write_in) && waitrequest_out |=>
    !waitrequest_out ##1 waitrequest_out)
    else $error("bus answer not one cycle");
  c_pwm_period: cover property (
    is_pwm && pmatch ##[1:1000] is_pwm && duty_hit);
  c_capture: cover property (cap_evt);
  c_compare: cover property (cmp_evt && mode == MODE_CMP_TRIG);
endmodule // ccp_unit

/* pwm_pin_monitor.sv */
// Monitor of the circuit fed by the unit output pin.
// Assumes the pin is registered on clock_in and driven as an output.
`timescale 1ns/1ps
module pwm_pin_monitor (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic [15:0] period_out,
  output logic [15:0] high_out,
  output logic [15:0] edges_out
);
  logic [15:0] cnt_reg;
  logic prev_reg;

  // Measures cycles between rises and from rise to fall
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_reg <= 16'h0;
      prev_reg <= 1'b0;
      period_out <= 16'h0;
      high_out <= 16'h0;
      edges_out <= 16'h0;
    end
    else
    begin
      prev_reg <= pin_in;
      cnt_reg <= cnt_reg + 16'h1;
      if (pin_in !== prev_reg)
      begin
        edges_out <= edges_out + 16'h1;
      end
      if (pin_in && !prev_reg)
      begin
        period_out <= cnt_reg;
        cnt_reg <= 16'h1;
      end
      if (!pin_in && prev_reg)
      begin
        high_out <= cnt_reg;
      end
    end
  end
endmodule // pwm_pin_monitor

/* capture_compare_pwm_unit_tb.sv */
// Self-checking bench for the capture/compare/PWM unit.
// Assumes the unit answers each Avalon request after one cycle.
`timescale 1ns/1ps
module capture_compare_pwm_unit_tb;
  import ccp_unit_pkg::*;
  logic clock_in, rst_in, read_in, write_in, capture_pin_in;
  logic [ADDR_W-1:0] address_in;
  logic [DATA_W-1:0] writedata_in, readdata_out, rd;
  logic [3:0] byteenable_in;
  logic waitrequest_out, unit_output_pin_out, conversion_start_out;
  logic [15:0] period_out, high_out, edges_out;
  logic [7:0] port_c_direction;
  logic conv_seen;
  int error_cnt = 0;
  int samples_checked = 0;

  ccp_unit i_ccp_unit (.clock_in(clock_in), .rst_in(rst_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .byteenable_in(byteenable_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .capture_pin_in(capture_pin_in),
    .unit_output_pin_out(unit_output_pin_out),
    .conversion_start_out(conversion_start_out));
  // Far side only sees the pin once its port bit is an output
  pwm_pin_monitor i_pwm_pin_monitor (.clock_in(clock_in), .rst_in(rst_in),
    .pin_in(unit_output_pin_out && !port_c_direction[2]),
    .period_out(period_out),
    .high_out(high_out), .edges_out(edges_out));

  // Remembers any conversion start pulse
  always @(posedge clock_in or posedge rst_in)
    if (rst_in)
      conv_seen <= 1'b0;
    else if (conversion_start_out)
      conv_seen <= 1'b1;

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clock_in);
    address_in <= {idx, 2'b00};
    writedata_in <= {24'h0, wd};
    write_in <= w;
    read_in <= !w;
    do
    begin
      @(posedge clock_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50)
      error_cnt++;
    r = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, rd);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h0, rd);
    check(rd, {24'h0, exp});
  endtask

  task automatic pwm_case(input logic [7:0] per, input logic [7:0] cfg,
    input logic [9:0] duty, input logic [15:0] ep, input logic [15:0] eh);
    logic [15:0] e;
    wr(IDX_UNIT_ONE_CONTROL, 8'h00);
    wr(IDX_TIMER_CONFIG, cfg);
    wr(IDX_PERIOD, per);
    wr(IDX_PERIOD_TIMER, 8'h00);
    wr(IDX_DUTY_MSB, duty[9:2]);
    wr(IDX_UNIT_ONE_CONTROL, {2'b00, duty[1:0], 4'hc});
    repeat (160) @(posedge clock_in);
    e = edges_out;
    if (ep != 16'h0)
    begin
      check(period_out, ep);
      check(high_out, eh);
    end
    else
    begin
      repeat (64) @(posedge clock_in);
      check(edges_out, e);
      check(unit_output_pin_out, eh[0]);
    end
  endtask

  task automatic cmp_case(input logic [3:0] mode, input logic ep);
    logic [31:0] lo, hi;
    logic [15:0] t;
    int n;
    bus(1'b0, IDX_COMPANION_LO, 8'h0, lo);
    bus(1'b0, IDX_COMPANION_HI, 8'h0, hi);
    t = {hi[7:0], lo[7:0]} + 16'h0040;
    wr(IDX_DUTY_SHADOW, t[15:8]);
    wr(IDX_DUTY_MSB, t[7:0]);
    wr(IDX_FLAGS, 8'h01);
    wr(IDX_UNIT_ONE_CONTROL, {4'h0, mode});
    n = 0;
    lo = 32'h0;
    while (lo[0] !== 1'b1 && n < 500)
    begin
      bus(1'b0, IDX_FLAGS, 8'h0, lo);
      n++;
    end
    check(lo[0], 1'b1);
    if (mode != MODE_CMP_TRIG)
      check(unit_output_pin_out, ep);
    else
      rdchk(IDX_COMPANION_HI, 8'h00);
    check(conv_seen, 1'b0);
  endtask

  task automatic pulse();
    @(posedge clock_in);
    capture_pin_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    capture_pin_in <= 1'b0;
    repeat (3) @(posedge clock_in);
  endtask

  task automatic cap_case(input logic [3:0] mode, input int edges);
    wr(IDX_UNIT_ONE_CONTROL, {4'h0, mode});
    wr(IDX_FLAGS, 8'h01);
    repeat (edges - 1) pulse();
    bus(1'b0, IDX_FLAGS, 8'h0, rd);
    check(rd[0], 1'b0);
    pulse();
    bus(1'b0, IDX_FLAGS, 8'h0, rd);
    check(rd[0], 1'b1);
  endtask

  initial
  begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  initial
  begin
    repeat (40000) @(posedge clock_in);
    error_cnt++;
    test_done();
  end

  initial
  begin
    rst_in = 1'b1;
    read_in = 1'b0;
    write_in = 1'b0;
    address_in = '0;
    writedata_in = '0;
    byteenable_in = 4'hf;
    capture_pin_in = 1'b0;
    port_c_direction = 8'hff;
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    rdchk(IDX_UNIT_ONE_CONTROL, 8'h00);
    rdchk(IDX_PERIOD, 8'hff);
    rdchk(8'h3f, 8'h00);
    wr(IDX_UNIT_ONE_CONTROL, 8'hff);
    rdchk(IDX_UNIT_ONE_CONTROL, 8'h3f);
    port_c_direction[2] <= 1'b0;
    pwm_case(8'h01, 8'h00, 10'd4, 16'd8, 16'd4);
    pwm_case(8'h03, 8'h3c, 10'd10, 16'd16, 16'd10);
    pwm_case(8'h01, 8'h01, 10'd4, 16'd32, 16'd16);
    pwm_case(8'h02, 8'h00, 10'd0, 16'd0, 16'd0);
    pwm_case(8'h01, 8'h00, 10'h3ff, 16'd0, 16'd1);
    wr(IDX_UNIT_ONE_CONTROL, 8'h00);
    repeat (2) @(posedge clock_in);
    check(unit_output_pin_out, 1'b0);
    wr(IDX_PERIOD, 8'hff);
    wr(IDX_TIMER_CONFIG, 8'h02);
    wr(IDX_UNIT_ONE_CONTROL, 8'h0c);
    wr(IDX_DUTY_MSB, 8'h12);
    rdchk(IDX_DUTY_SHADOW, 8'hff);
    wr(IDX_DUTY_SHADOW, 8'h55);
    rdchk(IDX_DUTY_SHADOW, 8'hff);
    rdchk(IDX_DUTY_MSB, 8'h12);
    wr(IDX_UNIT_ONE_CONTROL, 8'h00);
    cmp_case(MODE_CMP_SET, 1'b1);
    cmp_case(MODE_CMP_SOFT, 1'b1);
    cmp_case(MODE_CMP_CLR, 1'b0);
    cmp_case(MODE_CMP_TRIG, 1'b0);
    cap_case(MODE_CAP_RISE, 1);
    cap_case(MODE_CAP_RISE4, 4);
    cap_case(MODE_CAP_RISE16, 16);
    cap_case(MODE_CAP_FALL, 1);
    test_done();
  end
endmodule // capture_compare_pwm_unit_tb
